// ==== sim/cfps_power_stage.sv ====
`timescale 1ns/1ns
`default_nettype none
module cfps_power_stage
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // pulse train control
  input  wire logic       go,
  input  wire logic [7:0] width,
  // modulator request and gate feedback
  output logic            pwm_low_req,
  input  wire logic       gate,
  output logic [7:0]      gate_ends
);
  logic [7:0] ph;
  logic       gate_d;

  // a started pulse always runs to its end, so a train is never cut short
  always_ff @(posedge clk)
  begin
    gate_d <= gate;
    if (rst)
    begin
      ph <= 8'h00;
      pwm_low_req <= 1'b0;
      gate_ends <= 8'h00;
    end
    else
    begin
      if (gate_d && !gate)
        gate_ends <= gate_ends + 8'h01;
      pwm_low_req <= (go || ph != 8'h00) && ph < width;
      if (go || ph != 8'h00)
        ph <= (ph == width + 8'h03) ? 8'h00 : ph + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== sim/converter_fault_protection_sequencer_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module converter_fault_protection_sequencer_bench;
  localparam int PWR_LIM_C = 20;
  localparam int FDR_C     = 200;
  localparam int LIMIT     = 20000;
  typedef struct {int due; int kind; logic [7:0] val;} cfps_note_t;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       supply_on = 1'b0;
  logic       supply_off = 1'b0;
  logic       over_pwr = 1'b0;
  logic       aux_low = 1'b0;
  logic       therm_low = 1'b0;
  logic       ss = 1'b0;
  logic       frh = 1'b0;
  logic       go = 1'b0;
  logic       clr = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] width = 8'h04;
  logic [3:0] pf = 4'h0;
  logic [2:0] sf = 3'h0;
  logic       req;
  logic       gate;
  logic       thr;
  logic       run;
  logic       rec;
  logic       lock;
  logic [7:0] clamp;
  logic [7:0] ends;
  int         cyc = 0;
  int         fails = 0;
  int         cmp_count = 0;
  int         seed = 19987;
  cfps_note_t q[$];
  cfps_note_t nt;

  always #50 clk = ~clk;

  cfps_sequencer #(.PWR_CYCLES(PWR_LIM_C), .FDR_CYCLES(FDR_C)) cfps_sequencer_i
  (
    .clk(clk), .rst(rst), .supply_on(supply_on), .supply_off(supply_off),
    .pwm_low_req(req), .peak_current_command(cmd),
    .thermistor_low(therm_low), .cmd_over_pwr(over_pwr),
    .aux_below_short(aux_low), .cs_ovc_window_hit(pf[3]),
    .cs_at_ovc_level(pf[2]), .greg_over_ov(pf[1]),
    .greg_below_12v(sf[2]), .junction_hot(pf[0] | sf[0]),
    .timing_pin_fault(sf[1]), .silicon_select(ss),
    .freq_res_above_th(frh), .low_side_gate_pulse(gate),
    .peak_current_clamp(clamp), .thermistor_thr_high(thr), .run(run),
    .recovery_active(rec), .lockout_active(lock)
  );

  cfps_power_stage cfps_power_stage_i
  (
    .clk(clk), .rst(rst | clr), .go(go), .width(width),
    .pwm_low_req(req), .gate(gate), .gate_ends(ends)
  );

  task automatic cmp_code(input string nm, input logic [7:0] e,
                          input logic [7:0] s);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmp_stat(input string nm, input logic [3:0] e,
                          input logic [3:0] s);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic results();
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watcher: cycle count moves on the falling edge, where outputs are settled
  always @(negedge clk)
  begin
    cyc <= cyc + 1;
    while (q.size() > 0 && q[0].due <= cyc)
    begin
      nt = q.pop_front();
      case (nt.kind)
        0: cmp_code("peak_current_clamp", nt.val, clamp);
        1: cmp_stat("run_rec_lock_thr", nt.val[3:0], {run, rec, lock, thr});
        2: cmp_code("gate_ends", nt.val, ends);
        default: cmp_stat("thermistor_thr_high", {3'h0, nt.val[0]},
                          {3'h0, thr});
      endcase
    end
    if (cyc == LIMIT)
    begin
      fails++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic note(input int k, input logic [7:0] v, input int d);
    q.push_back('{cyc + d, k, v});
  endtask

  task automatic start();
    supply_on <= 1'b1;
    tick(1);
    supply_on <= 1'b0;
    tick(104);
  endtask

  task automatic off();
    supply_off <= 1'b1;
    tick(1);
    supply_off <= 1'b0;
    tick(3);
  endtask

  task automatic pulses(input int n, input int w);
    clr <= 1'b1;
    width <= w[7:0];
    tick(1);
    clr <= 1'b0;
    go <= 1'b1;
    tick(n * (w + 4));
    go <= 1'b0;
    tick(w + 8);
  endtask

  // recovery must swallow requests and outlast one early turn-off
  task automatic fin_rec();
    pulses(2, 4);
    note(2, 8'h00, 0);
    off();
    note(1, 8'h04, 0);
    tick(FDR_C);
    off();
    note(1, 8'h00, 0);
  endtask

  initial
  begin
    int         w;
    logic [7:0] v;
    tick(4);
    rst <= 1'b0;
    note(1, 8'h00, 0);
    start();
    note(1, 8'h08, 0);
    for (int i = 0; i < 24; i++)
    begin
      v = (i < 4) ? 8'hc7 + 8'(i) : 8'($random(seed));
      v = (i == 3) ? 8'hff : v;
      cmd <= v;
      note(0, (v > 8'hc8) ? 8'(cfps_pkg::PEAK_CEIL_CODE) : v, 1);
      tick(1);
    end
    off();
    for (int j = 0; j < 6; j++)
    begin
      {ss, frh} <= (j < 2) ? 2'b10 : (j < 4) ? 2'b01 : 2'b00;
      w = ((j < 4) ? cfps_pkg::CSF_LONG_CYC : cfps_pkg::CSF_SHORT_CYC) + j % 2;
      start();
      pulses(1, w);
      note(1, (j % 2 == 1) ? 8'h04 : 8'h08, 0);
      if (j % 2 == 1)
        fin_rec();
      else
        off();
    end
    start();
    over_pwr <= 1'b1;
    tick(PWR_LIM_C - 2);
    over_pwr <= 1'b0;
    tick(1);
    over_pwr <= 1'b1;
    tick(PWR_LIM_C - 2);
    note(1, 8'h08, 0);
    tick(4);
    note(1, 8'h04, 0);
    over_pwr <= 1'b0;
    fin_rec();
    for (int k = 0; k < 3; k++)
    begin
      start();
      over_pwr <= (k == 1);
      aux_low <= (k == 2);
      tick(1);
      off();
      note(1, (k > 0) ? 8'h04 : 8'h00, 0);
      over_pwr <= 1'b0;
      aux_low <= 1'b0;
      if (k > 0)
        fin_rec();
    end
    for (int k = 0; k < 3; k++)
    begin
      sf <= 3'h1 << k;
      start();
      note(1, 8'h02, 0);
      sf <= 3'h0;
      off();
      note(1, 8'h00, 0);
    end
    for (int k = 0; k < 4; k++)
    begin
      start();
      pf <= 4'h1 << k;
      pulses(2, 4);
      pf <= 4'h0;
      pulses(1, 4);
      pf <= 4'h1 << k;
      pulses(2, 4);
      note(1, 8'h08, 0);
      pulses(1, 4);
      note(1, (k > 1) ? 8'h04 : 8'h02, 0);
      pf <= 4'h0;
      if (k > 1)
        fin_rec();
      else
        off();
    end
    start();
    therm_low <= 1'b1;
    pulses(3, 4);
    note(3, 8'h00, 0);
    pulses(1, 4);
    note(3, 8'h01, 0);
    off();
    start();
    note(1, 8'h01, 0);
    pulses(3, 4);
    note(2, 8'h03, 0);
    note(3, 8'h01, 0);
    off();
    start();
    therm_low <= 1'b0;
    pulses(1, 4);
    note(1, 8'h08, 0);
    off();
    tick(4);
    results();
  end
endmodule
`default_nettype wire

// ==== src/cfps_pkg.sv ====
package cfps_pkg;

  // clock and derived cycle counts
  localparam int CLK_PERIOD_NS      = 100;
  localparam int GREG_CHK_DELAY_NS  = 10000;
  localparam int GREG_CHK_CYC       =
    (GREG_CHK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSF_LONG_NS        = 2000;
  localparam int CSF_SHORT_NS       = 1000;
  localparam int CSF_LONG_CYC       = CSF_LONG_NS / CLK_PERIOD_NS;
  localparam int CSF_SHORT_CYC      = CSF_SHORT_NS / CLK_PERIOD_NS;
  localparam int PWR_TIMER_MS       = 160;
  localparam int PWR_TIMER_CYC      =
    PWR_TIMER_MS * (1000000 / CLK_PERIOD_NS);
  localparam int FDR_MS             = 1500;
  localparam int FDR_CYC            = FDR_MS * (1000000 / CLK_PERIOD_NS);

  // consecutive low-side pulse counts
  localparam int OTP_TRIP_PULSES  = 4;
  localparam int FAULT_RUN_PULSES = 3;
  localparam int OTP_TEST_PULSES  = 3;

  // peak current command coding
  localparam int CMD_W          = 8;
  localparam int CMD_LSB_MV     = 4;
  localparam int PEAK_CEIL_MV   = 800;
  localparam int PEAK_CEIL_CODE = PEAK_CEIL_MV / CMD_LSB_MV;

  // pulse-run fault channels
  localparam int CH_OTP    = 0;
  localparam int CH_OVC    = 1;
  localparam int CH_CSOPEN = 2;
  localparam int CH_HVGOV  = 3;
  localparam int CH_TSD    = 4;
  localparam int NUM_CH    = 5;

  typedef enum logic [2:0]
  {
    ST_WAIT_ON,
    ST_PIN_CHECK,
    ST_RUN,
    ST_LOCKOUT,
    ST_RECOVER
  } cfps_state_t;

endpackage

// ==== src/cfps_run_counter.sv ====
`timescale 1ns/1ns
`default_nettype none
module cfps_run_counter
#(
  parameter int unsigned THRESH = 3
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic clear,
  input  wire logic sample,
  input  wire logic cond,
  // result
  output logic      hit
);

  localparam int W = $clog2(THRESH + 1);

  typedef struct packed
  {
    logic [W-1:0] count;
  } cfps_cnt_t;

  cfps_cnt_t s_reg;
  cfps_cnt_t s_next;

  generate
    if (THRESH < 1)
    begin : g_bad
      $error("run counter threshold must be at least one");
    end
  endgenerate

  always_comb
  begin
    s_next = s_reg;
    if (clear)
      s_next.count = '0;
    else if (sample)
    begin
      if (!cond)
        s_next.count = '0; // [R18]
      else if (s_reg.count != W'(THRESH))
        s_next.count = s_reg.count + W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign hit = (s_reg.count == W'(THRESH));

  a_run_broken: assert property (@(posedge clk) disable iff (rst) // [R18]
    sample && !cond && !clear |=> !hit ##0 s_reg.count == '0)
    else $error("pulse run not restarted after clean pulse");

endmodule
`default_nettype wire

// ==== src/cfps_sequencer.sv ====
// Behaviour
// R1 - thermistor low on over three consecutive pulses sets over-temperature
// R2 - entering over-temperature raises thermistor threshold to the high level
// R3 - over-temperature latched until release seen, then normal threshold
// R4 - shorted thermistor: lockout cycles, each with three test pulses
// R5 - command above over-power threshold runs timer, restarting when it drops
// R6 - command above threshold for 160 ms stops switching, starts recovery
// R7 - peak current command is clamped to the 0.8 V ceiling
// R8 - at supply turn-off, over-power or low aux sense starts recovery
// R9 - turn-off without short sign gives only an ordinary lockout restart
// R10 - three over-current cycles stop switching, drop run, start recovery
// R11 - recovery: no pulses; after interval, next turn-off restarts normally
// R12 - junction over-temperature: lockout restart, repeated while still hot
// R13 - first pulse on-time beyond selected limit starts recovery
// R14 - gate-regulator pin low at 10 us after turn-on gives one lockout
// R15 - current sense at open level three pulses starts recovery
// R16 - gate-regulator overvoltage on three pulses gives one lockout
// R17 - timing-pin open or short at turn-on gives one lockout
// R18 - consecutive-pulse counters clear on any pulse without the condition
`timescale 1ns/1ns
`default_nettype none
module cfps_sequencer
#(
  parameter int PWR_CYCLES = cfps_pkg::PWR_TIMER_CYC,
  parameter int FDR_CYCLES = cfps_pkg::FDR_CYC
)
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // supply lockout events
  input  wire logic                       supply_on,
  input  wire logic                       supply_off,
  // modulator
  input  wire logic                       pwm_low_req,
  input  wire logic [cfps_pkg::CMD_W-1:0] peak_current_command,
  // comparator results
  input  wire logic                       thermistor_low,
  input  wire logic                       cmd_over_pwr,
  input  wire logic                       aux_below_short,
  input  wire logic                       cs_ovc_window_hit,
  input  wire logic                       cs_at_ovc_level,
  input  wire logic                       greg_over_ov,
  input  wire logic                       greg_below_12v,
  input  wire logic                       junction_hot,
  input  wire logic                       timing_pin_fault,
  // straps
  input  wire logic                       silicon_select,
  input  wire logic                       freq_res_above_th,
  // outputs
  output logic                            low_side_gate_pulse,
  output logic [cfps_pkg::CMD_W-1:0]      peak_current_clamp,
  output logic                            thermistor_thr_high,
  output logic                            run,
  output logic                            recovery_active,
  output logic                            lockout_active
);

  localparam int TW = $clog2(FDR_CYCLES + 1);
  localparam int OW = $clog2(PWR_CYCLES + 1);
  localparam logic [TW-1:0] GREG_LAST = TW'(cfps_pkg::GREG_CHK_CYC - 1);
  localparam logic [TW-1:0] FDR_END   = TW'(FDR_CYCLES);
  localparam logic [OW-1:0] PWR_LAST  = OW'(PWR_CYCLES - 1);
  localparam logic [cfps_pkg::CMD_W-1:0] CEIL =
    cfps_pkg::CMD_W'(cfps_pkg::PEAK_CEIL_CODE);

  typedef struct packed
  {
    cfps_pkg::cfps_state_t             state;
    logic [TW-1:0]                     timer;
    logic [OW-1:0]                     pwr_cnt;
    logic [7:0]                        on_cnt;
    logic                              first_done;
    logic [1:0]                        test_cnt;
    logic                              otp_latched;
    logic                              gate;
    logic [cfps_pkg::CMD_W-1:0]        clamp;
    logic                              run;
  } cfps_seq_t;

  cfps_seq_t                  s_reg;
  cfps_seq_t                  s_next;
  logic [cfps_pkg::NUM_CH-1:0] cond;
  logic [cfps_pkg::NUM_CH-1:0] hit;
  logic                       pulse_end;
  logic                       in_run;
  logic [7:0]                 on_limit;

  generate
    if (PWR_CYCLES < 2 || FDR_CYCLES < cfps_pkg::GREG_CHK_CYC)
    begin : g_bad
      $error("timer parameters too small for this sequencer");
    end
  endgenerate

  assign in_run    = (s_reg.state == cfps_pkg::ST_RUN);
  assign pulse_end = s_reg.gate && !s_next.gate;

  // thermistor trip counting is suspended while latched; release is tested
  assign cond[cfps_pkg::CH_OTP]    = thermistor_low && !s_reg.otp_latched;
  assign cond[cfps_pkg::CH_OVC]    = cs_ovc_window_hit;
  assign cond[cfps_pkg::CH_CSOPEN] = cs_at_ovc_level;
  assign cond[cfps_pkg::CH_HVGOV]  = greg_over_ov;
  assign cond[cfps_pkg::CH_TSD]    = junction_hot;

  generate
    for (genvar ch = 0; ch < cfps_pkg::NUM_CH; ch++)
    begin : g_ch
      cfps_run_counter
      #(
        .THRESH ((ch == cfps_pkg::CH_OTP) ? cfps_pkg::OTP_TRIP_PULSES
                                          : cfps_pkg::FAULT_RUN_PULSES)
      )
      u_cnt
      (
        .clk    (clk),
        .rst    (rst),
        .clear  (!in_run),
        .sample (pulse_end),   // [R18]
        .cond   (cond[ch]),
        .hit    (hit[ch])
      );
    end
  endgenerate

  // long limit for silicon, or for gallium with a slow frequency resistor
  assign on_limit = (silicon_select || freq_res_above_th)
                  ? 8'(cfps_pkg::CSF_LONG_CYC)
                  : 8'(cfps_pkg::CSF_SHORT_CYC); // [R13]

  always_comb
  begin
    logic go_recover;
    logic go_lock;
    s_next     = s_reg;
    go_recover = 1'b0;
    go_lock    = 1'b0;
    s_next.gate  = 1'b0;
    s_next.clamp = (peak_current_command > CEIL)
                 ? CEIL : peak_current_command; // [R7]
    unique case (s_reg.state)
      cfps_pkg::ST_WAIT_ON:
      begin
        s_next.run   = 1'b0;
        s_next.timer = '0;
        if (supply_on)
          s_next.state = cfps_pkg::ST_PIN_CHECK;
      end
      cfps_pkg::ST_PIN_CHECK:
      begin
        s_next.timer      = s_reg.timer + TW'(1);
        s_next.first_done = 1'b0;
        s_next.on_cnt     = '0;
        s_next.pwr_cnt    = '0;
        s_next.test_cnt   = '0;
        if (supply_off)
          s_next.state = cfps_pkg::ST_WAIT_ON;
        else if (s_reg.timer == GREG_LAST)
        begin
          // pin faults and a still-hot junction skip switching entirely
          if (greg_below_12v || timing_pin_fault || junction_hot)
            s_next.state = cfps_pkg::ST_LOCKOUT; // [R14] [R17] [R12]
          else
          begin
            s_next.state = cfps_pkg::ST_RUN;
            s_next.run   = !s_reg.otp_latched;
          end
        end
      end
      cfps_pkg::ST_RUN:
      begin
        s_next.gate = pwm_low_req;
        if (!s_reg.first_done && s_reg.gate)
        begin
          if (s_reg.on_cnt == on_limit)
            go_recover = 1'b1; // [R13]
          s_next.on_cnt = s_reg.on_cnt + 8'(1);
        end
        if (pulse_end)
          s_next.first_done = 1'b1;
        if (cmd_over_pwr)
        begin
          s_next.pwr_cnt = s_reg.pwr_cnt + OW'(1); // [R5]
          if (s_reg.pwr_cnt == PWR_LAST)
            go_recover = 1'b1; // [R6]
        end
        else
          s_next.pwr_cnt = '0; // [R5]
        if (hit[cfps_pkg::CH_OVC] || hit[cfps_pkg::CH_CSOPEN])
          go_recover = 1'b1; // [R10] [R15]
        if (hit[cfps_pkg::CH_HVGOV] || hit[cfps_pkg::CH_TSD])
          go_lock = 1'b1; // [R16] [R12]
        if (hit[cfps_pkg::CH_OTP])
        begin
          s_next.otp_latched = 1'b1; // [R1] [R2]
          go_lock            = 1'b1;
        end
        if (s_reg.otp_latched && pulse_end)
        begin
          // comparator now sits at the raised threshold
          if (!thermistor_low)
          begin
            s_next.otp_latched = 1'b0; // [R3]
            s_next.run         = 1'b1;
          end
          else if (s_reg.test_cnt == 2'(cfps_pkg::OTP_TEST_PULSES - 1))
            go_lock = 1'b1; // [R4]
          else
            s_next.test_cnt = s_reg.test_cnt + 2'(1); // [R4]
        end
        if (supply_off)
        begin
          s_next.gate = 1'b0;
          s_next.run  = 1'b0;
          s_next.timer = '0;
          if (cmd_over_pwr || aux_below_short)
            s_next.state = cfps_pkg::ST_RECOVER; // [R8]
          else
            s_next.state = cfps_pkg::ST_WAIT_ON; // [R9]
        end
        else if (go_recover)
        begin
          s_next.state = cfps_pkg::ST_RECOVER;
          s_next.timer = '0;
          s_next.gate  = 1'b0;
          s_next.run   = 1'b0; // [R10]
        end
        else if (go_lock)
        begin
          s_next.state = cfps_pkg::ST_LOCKOUT;
          s_next.gate  = 1'b0;
          s_next.run   = 1'b0;
        end
      end
      cfps_pkg::ST_LOCKOUT:
      begin
        s_next.run = 1'b0;
        if (supply_off)
          s_next.state = cfps_pkg::ST_WAIT_ON; // [R3] [R12]
      end
      cfps_pkg::ST_RECOVER:
      begin
        s_next.run = 1'b0;
        if (s_reg.timer != FDR_END)
          s_next.timer = s_reg.timer + TW'(1);
        if (supply_off && s_reg.timer == FDR_END)
          s_next.state = cfps_pkg::ST_WAIT_ON; // [R11]
      end
      default:
        s_next.state = cfps_pkg::ST_WAIT_ON;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign low_side_gate_pulse = s_reg.gate;
  assign peak_current_clamp  = s_reg.clamp;
  assign thermistor_thr_high = s_reg.otp_latched; // [R2] [R3]
  assign run                 = s_reg.run;
  assign recovery_active     = (s_reg.state == cfps_pkg::ST_RECOVER);
  assign lockout_active      = (s_reg.state == cfps_pkg::ST_LOCKOUT);

  a_clamp_ceiling: assert property (@(posedge clk) disable iff (rst) // [R7]
    peak_current_command > CEIL |=> peak_current_clamp == CEIL)
    else $error("peak command not clamped");

  a_power_restart: assert property (@(posedge clk) disable iff (rst) // [R5]
    in_run && !cmd_over_pwr && !supply_off |=> s_reg.pwr_cnt == '0)
    else $error("over-power timer not restarted");

  a_power_expiry: assert property (@(posedge clk) disable iff (rst) // [R6]
    in_run && cmd_over_pwr && s_reg.pwr_cnt == PWR_LAST
    |=> recovery_active && !low_side_gate_pulse)
    else $error("over-power expiry did not start recovery");

  a_short_check: assert property (@(posedge clk) disable iff (rst) // [R8]
    in_run && supply_off && (cmd_over_pwr || aux_below_short)
    |=> recovery_active && s_reg.timer == '0)
    else $error("output short not sent to recovery");

  a_plain_restart: assert property (@(posedge clk) disable iff (rst) // [R9]
    in_run && supply_off && !cmd_over_pwr && !aux_below_short
    |=> s_reg.state == cfps_pkg::ST_WAIT_ON)
    else $error("plain turn-off did not restart normally");

  a_recover_quiet: assert property (@(posedge clk) disable iff (rst) // [R11]
    recovery_active && s_reg.timer != FDR_END
    |=> recovery_active && !low_side_gate_pulse && !run)
    else $error("recovery left early or switched");

  a_overcur_stop: assert property (@(posedge clk) disable iff (rst) // [R10]
    in_run && !supply_off && hit[cfps_pkg::CH_OVC]
    |=> recovery_active && !run)
    else $error("over-current run did not stop");

  a_otp_latch: assert property (@(posedge clk) disable iff (rst) // [R2]
    $rose(thermistor_thr_high) |-> lockout_active)
    else $error("threshold raised without lockout");

  a_greg_check: assert property (@(posedge clk) disable iff (rst) // [R14]
    s_reg.state == cfps_pkg::ST_PIN_CHECK && s_reg.timer == GREG_LAST
    && !supply_off && greg_below_12v
    |=> lockout_active [*2] ##0 !low_side_gate_pulse)
    else $error("regulator pin fault not locked out");

  a_first_pulse: assert property (@(posedge clk) disable iff (rst) // [R13]
    in_run && !supply_off && !s_reg.first_done && s_reg.gate
    && s_reg.on_cnt == on_limit |=> recovery_active)
    else $error("long first pulse not caught");

endmodule
`default_nettype wire
